// ==== src/hpr_pkg.sv ====
// Constants and types for the host port ready logic.
// Assumes one 125 MHz clock and a synchronous active-high reset.
// Function
// - Strobe is not(ds1 xor ds2) or select.
// - Back-to-back address writes may hold ready low.
// - Address write after read-ahead may stall.
// - Data write stalls while buffer full/flushing.
// - Address write waits for pending write data.
// - Auto-increment read miss stalls first half.
// - Fixed data read first half waits fetch.
// - Auto-increment read hit keeps ready high.
// - Second half of fixed read never stalls.
// - Control and address reads never stall.
// - Buffered read data driven at strobe fall.
// - After data write, full buffer drops ready.
// - After address write, ready low while busy.
// - Fixed data write stalls after second half.
// - Otherwise writes keep ready high.
package hpr_pkg;

   localparam int HPR_HALF_W = 16;
   localparam int HPR_WORD_W = 32;
   localparam int HPR_PIN_W  = 23;

   // Register select codes on the two control pins.
   localparam logic [1:0] HPR_SEL_CTRL  = 2'h0;
   localparam logic [1:0] HPR_SEL_ADDR  = 2'h1;
   localparam logic [1:0] HPR_SEL_DINC  = 2'h2;
   localparam logic [1:0] HPR_SEL_DFIX  = 2'h3;

   localparam logic       HPR_HW_FIRST  = 1'h0;
   localparam logic [1:0] HPR_BUF_FULL  = 2'h2;
   localparam logic [1:0] HPR_BUF_ONE   = 2'h1;
   localparam logic [1:0] HPR_BUF_EMPTY = 2'h0;

   typedef enum logic [2:0] {
      HPR_ST_IDLE  = 3'b000,
      HPR_ST_HOLD  = 3'b001,
      HPR_ST_ACT   = 3'b010,
      HPR_ST_POST  = 3'b011,
      HPR_ST_FETCH = 3'b100
   } hpr_state_t;

endpackage : hpr_pkg

// ==== src/hpr_sync.sv ====
// Two-stage synchroniser for a group of host pins.
// Assumes the pins are asynchronous to clk_sys_in.
`timescale 1ns/1ps
module hpr_sync
   import hpr_pkg::*;
#(
   parameter int W = HPR_PIN_W
) (
   input  wire logic         clk_sys_in,
   input  wire logic         reset_in,
   input  wire logic [W-1:0] sync_in,
   output logic [W-1:0]      sync_out
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } hpr_sync_t;

   hpr_sync_t q, d;

   always_comb begin
      d    = q;
      d.s1 = sync_in;
      d.s2 = q.s1;
   end

   // Strobes idle high, so the stages reset to all ones.
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         q <= '1;
      end else begin
         q <= d;
      end
   end

   assign sync_out = q.s2;

endmodule : hpr_sync

// ==== src/hpr_buf.sv ====
// Two-entry buffer with valid and ready on both sides.
// Assumes both sides sit on clk_sys_in.
`timescale 1ns/1ps
module hpr_buf
   import hpr_pkg::*;
#(
   parameter int W = HPR_WORD_W + 1
) (
   input  wire logic         clk_sys_in,
   input  wire logic         reset_in,
   input  wire logic         in_valid_in,
   output logic              in_ready_out,
   input  wire logic [W-1:0] in_data_in,
   output logic              out_valid_out,
   input  wire logic         out_ready_in,
   output logic [W-1:0]      out_data_out,
   output logic [1:0]        count_out
);

   typedef struct packed {
      logic [W-1:0] m0;
      logic [W-1:0] m1;
      logic [1:0]   cnt;
   } hpr_buf_t;

   hpr_buf_t q, d;
   logic     push;
   logic     pop;

   assign in_ready_out  = (q.cnt != HPR_BUF_FULL);
   assign out_valid_out = (q.cnt != HPR_BUF_EMPTY);
   assign out_data_out  = q.m0;
   assign count_out     = q.cnt;
   assign push          = in_valid_in & in_ready_out;
   assign pop           = out_valid_out & out_ready_in;

   always_comb begin
      d = q;
      if (pop) begin
         d.m0  = q.m1;
         d.cnt = q.cnt - HPR_BUF_ONE;
      end
      if (push) begin
         if (d.cnt == HPR_BUF_EMPTY) begin
            d.m0 = in_data_in;
         end else begin
            d.m1 = in_data_in;
         end
         d.cnt = d.cnt + HPR_BUF_ONE;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

endmodule : hpr_buf

// ==== src/hpr_ready_logic.sv ====
// Ready and strobe logic of the 16-bit multiplexed host port.
// Assumes host pins are asynchronous and the device side sits on
// clk_sys_in; the host waits for ready before moving on.
`timescale 1ns/1ps
module hpr_ready_logic
   import hpr_pkg::*;
(
   input  wire logic                  clk_sys_in,
   input  wire logic                  reset_in,
   input  wire logic                  host_chip_select_in,
   input  wire logic                  host_data_strobe_one_in,
   input  wire logic                  host_data_strobe_two_in,
   input  wire logic                  host_read_not_write_in,
   input  wire logic [1:0]            host_reg_select_in,
   input  wire logic                  host_half_word_in,
   input  wire logic [HPR_HALF_W-1:0] host_data_bus_in,
   output logic [HPR_HALF_W-1:0]      host_data_bus_out,
   output logic                       host_data_bus_oe_out,
   output logic                       host_ready_out,
   input  wire logic [HPR_WORD_W-1:0] ctrl_value_in,
   output logic [HPR_WORD_W-1:0]      reg_word_out,
   output logic                       ctrl_write_out,
   output logic                       addr_write_out,
   input  wire logic                  addr_busy_in,
   input  wire logic                  read_ahead_busy_in,
   input  wire logic                  flushing_in,
   input  wire logic                  wr_fifo_empty_in,
   output logic                       wr_valid_out,
   input  wire logic                  wr_ready_in,
   output logic [HPR_WORD_W-1:0]      wr_word_out,
   output logic                       wr_auto_inc_out,
   input  wire logic                  rd_avail_in,
   input  wire logic [HPR_WORD_W-1:0] rd_data_in,
   output logic                       rd_take_out,
   output logic                       fetch_req_out,
   input  wire logic                  fetch_done_in,
   input  wire logic [HPR_WORD_W-1:0] fetch_data_in
);

   ////////////////////////////////////////////////////////////////////
   // Pin synchronisation and strobe forming.

   typedef struct packed {
      hpr_state_t                  st;
      logic                        rdy;
      logic                        oe;
      logic [HPR_HALF_W-1:0]       dout;
      logic [HPR_HALF_W-1:0]       lo;
      logic [HPR_WORD_W-1:0]       rword;
      logic [HPR_WORD_W-1:0]       addr;
      logic [HPR_WORD_W-1:0]       word;
      logic [1:0]                  sel;
      logic                        rnw;
      logic                        hw;
      logic                        last_addr;
      logic                        strb_prev;
      logic                        fetch;
      logic                        take;
      logic                        push;
      logic                        awr;
      logic                        cwr;
   } hpr_core_t;

   hpr_core_t             q, d;
   logic [HPR_PIN_W-1:0]  pins_s;
   logic                  s_cs;
   logic                  s_ds1;
   logic                  s_ds2;
   logic                  s_rnw;
   logic [1:0]            s_sel;
   logic                  s_hw;
   logic [HPR_HALF_W-1:0] s_data;
   logic                  strb_n;
   logic                  fall;
   logic                  rise;
   logic                  buf_in_ready;
   logic                  buf_out_valid;
   logic [1:0]            buf_count;
   logic                  wr_pending;
   logic [1:0]            cur_sel;
   logic                  hold_w;
   logic                  post_hold;
   logic [HPR_HALF_W-1:0] rd_imm;

   hpr_sync #(
      .W (HPR_PIN_W)
   ) u_sync (
      .clk_sys_in (clk_sys_in),
      .reset_in   (reset_in),
      .sync_in    ({host_chip_select_in, host_data_strobe_one_in,
                    host_data_strobe_two_in, host_read_not_write_in,
                    host_reg_select_in, host_half_word_in,
                    host_data_bus_in}),
      .sync_out   (pins_s)
   );

   assign {s_cs, s_ds1, s_ds2, s_rnw, s_sel, s_hw, s_data} = pins_s;

   // Either data strobe may start the access; select gates both.
   assign strb_n = ~(s_ds1 ^ s_ds2) | s_cs;
   assign fall   = q.strb_prev & ~strb_n;
   assign rise   = ~q.strb_prev & strb_n;

   ////////////////////////////////////////////////////////////////////
   // Write word buffer toward the write FIFO.

   hpr_buf #(
      .W (HPR_WORD_W + 1)
   ) u_buf (
      .clk_sys_in    (clk_sys_in),
      .reset_in      (reset_in),
      .in_valid_in   (q.push),
      .in_ready_out  (buf_in_ready),
      .in_data_in    ({q.sel == HPR_SEL_DINC, q.word}),
      .out_valid_out (buf_out_valid),
      .out_ready_in  (wr_ready_in),
      .out_data_out  ({wr_auto_inc_out, wr_word_out}),
      .count_out     (buf_count)
   );

   assign wr_valid_out = buf_out_valid;
   assign wr_pending   = buf_out_valid | ~wr_fifo_empty_in;
   assign cur_sel      = (q.st == HPR_ST_IDLE) ? s_sel : q.sel;

   ////////////////////////////////////////////////////////////////////
   // Stall decisions.

   always_comb begin
      hold_w = 1'b0;
      unique case (cur_sel)
         HPR_SEL_ADDR: begin
            hold_w = (q.last_addr & addr_busy_in)
                   | read_ahead_busy_in
                   | wr_pending;
         end
         HPR_SEL_DINC, HPR_SEL_DFIX:
            hold_w = ~buf_in_ready | flushing_in;
         HPR_SEL_CTRL: hold_w = 1'b0;
      endcase
   end

   always_comb begin
      post_hold = 1'b0;
      unique case (q.sel)
         HPR_SEL_ADDR: post_hold = q.awr | addr_busy_in;
         HPR_SEL_DFIX: post_hold = q.push | wr_pending;
         HPR_SEL_DINC: post_hold = q.push | ~buf_in_ready;
         HPR_SEL_CTRL: post_hold = 1'b0;
      endcase
   end

   // Half-words that are ready at the strobe fall.
   always_comb begin
      rd_imm = '0;
      unique case (s_sel)
         HPR_SEL_CTRL: begin
            rd_imm = s_hw ? ctrl_value_in[HPR_WORD_W-1:HPR_HALF_W]
                          : ctrl_value_in[HPR_HALF_W-1:0];
         end
         HPR_SEL_ADDR: begin
            rd_imm = s_hw ? q.addr[HPR_WORD_W-1:HPR_HALF_W]
                          : q.addr[HPR_HALF_W-1:0];
         end
         HPR_SEL_DINC, HPR_SEL_DFIX: begin
            rd_imm = s_hw ? q.rword[HPR_WORD_W-1:HPR_HALF_W]
                          : rd_data_in[HPR_HALF_W-1:0];
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // Access sequencer.

   always_comb begin
      d           = q;
      d.strb_prev = strb_n;
      d.fetch     = 1'b0;
      d.take      = 1'b0;
      d.push      = 1'b0;
      d.awr       = 1'b0;
      d.cwr       = 1'b0;
      unique case (q.st)
         HPR_ST_IDLE: begin
            if (fall) begin
               d.sel = s_sel;
               d.rnw = s_rnw;
               d.hw  = s_hw;
               if (s_rnw && s_sel == HPR_SEL_DFIX &&
                   s_hw == HPR_HW_FIRST) begin
                  d.fetch = 1'b1;
                  d.rdy   = 1'b0;
                  d.st    = HPR_ST_FETCH;
               end else if (s_rnw && s_sel == HPR_SEL_DINC &&
                            s_hw == HPR_HW_FIRST && !rd_avail_in) begin
                  d.rdy = 1'b0;
                  d.st  = HPR_ST_HOLD;
               end else if (s_rnw) begin
                  // Data already sits here, so no ready wait.
                  d.dout = rd_imm;
                  d.oe   = 1'b1;
                  d.st   = HPR_ST_ACT;
                  if (s_sel == HPR_SEL_DINC && s_hw == HPR_HW_FIRST) begin
                     d.rword = rd_data_in;
                  end
               end else if (hold_w) begin
                  d.rdy = 1'b0;
                  d.st  = HPR_ST_HOLD;
               end else begin
                  d.st = HPR_ST_ACT;
               end
            end
         end
         HPR_ST_HOLD: begin
            if (strb_n) begin
               // The host gave up; end quietly rather than lock up.
               d.rdy = 1'b1;
               d.st  = HPR_ST_IDLE;
            end else if (q.rnw) begin
               if (rd_avail_in) begin
                  d.rword = rd_data_in;
                  d.dout  = rd_data_in[HPR_HALF_W-1:0];
                  d.oe    = 1'b1;
                  d.rdy   = 1'b1;
                  d.st    = HPR_ST_ACT;
               end
            end else if (!hold_w) begin
               d.rdy = 1'b1;
               d.st  = HPR_ST_ACT;
            end
         end
         HPR_ST_FETCH: begin
            if (strb_n) begin
               d.rdy = 1'b1;
               d.st  = HPR_ST_IDLE;
            end else if (fetch_done_in) begin
               d.rword = fetch_data_in;
               d.dout  = fetch_data_in[HPR_HALF_W-1:0];
               d.oe    = 1'b1;
               d.rdy   = 1'b1;
               d.st    = HPR_ST_ACT;
            end
         end
         HPR_ST_ACT: begin
            if (rise) begin
               d.oe = 1'b0;
               d.st = HPR_ST_IDLE;
               if (q.rnw) begin
                  d.last_addr = 1'b0;
                  d.take = (q.sel == HPR_SEL_DINC) &&
                           (q.hw == HPR_HW_FIRST);
               end else if (q.hw == HPR_HW_FIRST) begin
                  d.lo = s_data;
               end else begin
                  d.word      = {s_data, q.lo};
                  d.last_addr = (q.sel == HPR_SEL_ADDR);
                  unique case (q.sel)
                     HPR_SEL_CTRL: d.cwr = 1'b1;
                     HPR_SEL_ADDR: begin
                        d.addr = {s_data, q.lo};
                        d.awr  = 1'b1;
                        d.rdy  = 1'b0;
                        d.st   = HPR_ST_POST;
                     end
                     HPR_SEL_DFIX: begin
                        d.push = 1'b1;
                        d.rdy  = 1'b0;
                        d.st   = HPR_ST_POST;
                     end
                     HPR_SEL_DINC: begin
                        d.push = 1'b1;
                        // One entry held means full once this lands.
                        if (buf_count != HPR_BUF_EMPTY) begin
                           d.rdy = 1'b0;
                           d.st  = HPR_ST_POST;
                        end
                     end
                  endcase
               end
            end
         end
         HPR_ST_POST: begin
            if (!post_hold) begin
               d.rdy = 1'b1;
               d.st  = HPR_ST_IDLE;
            end
         end
         default: begin
            d.rdy = 1'b1;
            d.oe  = 1'b0;
            d.st  = HPR_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         q           <= '0;
         q.st        <= HPR_ST_IDLE;
         q.rdy       <= 1'b1;
         q.strb_prev <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign host_data_bus_out    = q.dout;
   assign host_data_bus_oe_out = q.oe;
   assign host_ready_out       = q.rdy;
   assign reg_word_out         = q.word;
   assign ctrl_write_out       = q.cwr;
   assign addr_write_out       = q.awr;
   assign rd_take_out          = q.take;
   assign fetch_req_out        = q.fetch;

   ////////////////////////////////////////////////////////////////////
   // Checks.

   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (reset_in);

   logic idle_fall;
   assign idle_fall = (q.st == HPR_ST_IDLE) && fall;

   strobe_start_a: assert property (
      idle_fall |=> q.st != HPR_ST_IDLE)
      else $error("access not started on strobe fall");
   reg_read_rdy_a: assert property (
      idle_fall && s_rnw && !s_sel[1] |=> (q.rdy && q.oe) [*2])
      else $error("register read stalled");
   fix_fetch_a: assert property (
      idle_fall && s_rnw && s_sel == HPR_SEL_DFIX && !s_hw
      |=> !q.rdy && q.fetch)
      else $error("fixed read did not fetch");
   second_half_a: assert property (
      idle_fall && s_rnw && s_hw |=> q.rdy && q.oe)
      else $error("second half read stalled");
   inc_miss_a: assert property (
      idle_fall && s_rnw && s_sel == HPR_SEL_DINC && !rd_avail_in
      |=> (s_hw || !q.rdy))
      else $error("auto read miss handled wrongly");
   full_hold_a: assert property (
      idle_fall && !s_rnw && s_sel[1] && !buf_in_ready |=> !q.rdy)
      else $error("data write not stalled on full");
   addr_pend_a: assert property (
      idle_fall && !s_rnw && s_sel == HPR_SEL_ADDR && wr_pending
      |=> !q.rdy)
      else $error("address write not stalled");
   ahead_hold_a: assert property (
      q.st == HPR_ST_HOLD && !q.rnw && q.sel == HPR_SEL_ADDR &&
      read_ahead_busy_in && !strb_n |=> !q.rdy)
      else $error("read-ahead stall released early");
   addr_post_a: assert property (
      q.awr |-> !q.rdy ##1 !q.rdy)
      else $error("address write post stall missing");
   drive_only_a: assert property (
      q.oe |-> q.rnw && q.st == HPR_ST_ACT)
      else $error("bus driven outside read");
   ctrl_write_a: assert property (
      q.cwr |-> q.rdy)
      else $error("control write stalled");

   fix_read_c: cover property (q.fetch ##[1:20] q.oe);
   inc_miss_c: cover property (q.st == HPR_ST_HOLD && q.rnw ##1 q.oe);
   full_post_c: cover property (q.st == HPR_ST_POST && !buf_in_ready);
   addr_pair_c: cover property (q.last_addr && addr_busy_in && fall);

endmodule : hpr_ready_logic

// ==== dv/hpr_host_model.sv ====
// Host model: drives the host pins one half-word access at a time.
// Assumes the bench calls its tasks from a single thread.
`timescale 1ns/1ps
module hpr_host_model
   import hpr_pkg::*;
(
   input  wire logic                  clk_sys_in,
   input  wire logic                  ready_in,
   input  wire logic                  oe_in,
   input  wire logic [HPR_HALF_W-1:0] dev_data_in,
   output logic                       cs_n_out,
   output logic                       ds1_out,
   output logic                       ds2_out,
   output logic                       rnw_out,
   output logic [1:0]                 sel_out,
   output logic                       half_out,
   output logic [HPR_HALF_W-1:0]      drv_out,
   output logic                       done_out,
   output logic [HPR_HALF_W-1:0]      word_out
);
   initial begin
      {cs_n_out, ds1_out, ds2_out, rnw_out, sel_out, half_out} = 7'h7f;
      drv_out = 16'h0000;
      done_out = 1'b0;
      word_out = 16'h0000;
   end

   ////////////////////////////////////////////////////////////////////////
   // Bounded wait: a hung ready gives up after 300 cycles and counts each one in st.
   task automatic wait_ready(input logic r, inout int st);
      for (int n = 0; n < 300; n++) begin
         if (ready_in === 1'b1 && (!r || oe_in === 1'b1))
            break;
         st++;
         @(negedge clk_sys_in);
      end
   endtask : wait_ready

   task automatic access(input logic r, input logic [1:0] s, input logic h,
      input logic [15:0] w, output logic [15:0] rd, output int st,
      output logic oe_after);
      st = 0;
      @(negedge clk_sys_in);
      {rnw_out, sel_out, half_out} = {r, s, h};
      // A released bus shows the inverse of the last value, not a hold.
      drv_out = r ? ~drv_out : w;
      @(negedge clk_sys_in);
      cs_n_out = 1'b0;
      if ($urandom_range(1) == 1)
         ds1_out = ~ds2_out;
      else
         ds2_out = ~ds1_out;
      repeat (5) @(negedge clk_sys_in);
      wait_ready(r, st);
      rd = dev_data_in;
      word_out = rd;
      done_out = r;
      ds1_out = ds2_out;
      cs_n_out = 1'b1;
      @(negedge clk_sys_in);
      done_out = 1'b0;
      // Look at the bus enable while a post-write stall still stands.
      repeat (2) @(negedge clk_sys_in);
      oe_after = oe_in;
      wait_ready(1'b0, st);
   endtask : access

   task automatic idle_check(input logic [2:0] p, output logic bad);
      bad = 1'b0;
      @(negedge clk_sys_in);
      {cs_n_out, ds1_out, ds2_out} = p;
      repeat (8) begin
         @(negedge clk_sys_in);
         if (oe_in !== 1'b0 || ready_in !== 1'b1)
            bad = 1'b1;
      end
      {cs_n_out, ds1_out, ds2_out} = 3'h7;
      repeat (4) @(negedge clk_sys_in);
   endtask : idle_check
endmodule : hpr_host_model

// ==== dv/hpr_ready_logic_tb.sv ====
// Self-checking bench for the host port ready logic.
// Assumes hpr_host_model plays the host; the bench plays the core side.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin \
   bad_count++; $display("mismatch %s expected %h seen %h", nm, ex, got); \
   end end
module hpr_ready_logic_tb
   import hpr_pkg::*;
();
   logic clk_sys_in = 1'b0, reset_in = 1'b1;
   logic cs_n, ds1, ds2, rnw, half, done, oe, ready, cw, aw, wv, wai;
   logic rtk, freq, abusy = 1'b0, rbusy = 1'b0, flush = 1'b0;
   logic wemp = 1'b1, wrdy = 1'b1, ravl = 1'b0, fdone = 1'b0;
   logic [1:0]  sel;
   logic [15:0] drv, dout, word, bus;
   logic [31:0] cval = 32'h0, rword, wword, rdat = 32'h0, fdat = 32'h0;
   logic [36:0] exp_q[$];
   int bad_count = 0, compares = 0, fcnt = 0, takes = 0;

   assign bus = oe ? dout : drv;
   always #4 clk_sys_in = ~clk_sys_in;

   hpr_ready_logic dut_u (
      .clk_sys_in(clk_sys_in), .reset_in(reset_in),
      .host_chip_select_in(cs_n), .host_data_strobe_one_in(ds1),
      .host_data_strobe_two_in(ds2), .host_read_not_write_in(rnw),
      .host_reg_select_in(sel), .host_half_word_in(half),
      .host_data_bus_in(bus), .host_data_bus_out(dout),
      .host_data_bus_oe_out(oe), .host_ready_out(ready),
      .ctrl_value_in(cval), .reg_word_out(rword),
      .ctrl_write_out(cw), .addr_write_out(aw),
      .addr_busy_in(abusy), .read_ahead_busy_in(rbusy),
      .flushing_in(flush), .wr_fifo_empty_in(wemp),
      .wr_valid_out(wv), .wr_ready_in(wrdy),
      .wr_word_out(wword), .wr_auto_inc_out(wai),
      .rd_avail_in(ravl), .rd_data_in(rdat), .rd_take_out(rtk),
      .fetch_req_out(freq), .fetch_done_in(fdone), .fetch_data_in(fdat));

   hpr_host_model host_u (
      .clk_sys_in(clk_sys_in), .ready_in(ready), .oe_in(oe),
      .dev_data_in(bus), .cs_n_out(cs_n), .ds1_out(ds1), .ds2_out(ds2),
      .rnw_out(rnw), .sel_out(sel), .half_out(half), .drv_out(drv),
      .done_out(done), .word_out(word));

   ////////////////////////////////////////////////////////////////////////
   task automatic give_verdict;
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : give_verdict

   task automatic take(input logic [3:0] k, input logic [32:0] v);
      logic [36:0] n;
      if (exp_q.size() == 0) begin
         `CHK("unexpected result", 4'h0, k)
      end else begin
         n = exp_q.pop_front();
         `CHK("result kind", n[36:33], k)
         `CHK("result value", n[32:0], v)
      end
   endtask : take

   task automatic hw(input logic r, input logic [1:0] s, input logic h,
      input logic [15:0] w, output int st);
      logic [15:0] rd;
      logic        oe_after;
      host_u.access(r, s, h, w, rd, st, oe_after);
      `CHK("bus enable after strobe", 1'b0, oe_after)
   endtask : hw

   task automatic wr32(input logic [1:0] s, input logic [31:0] w,
      output int s0, output int s1);
      hw(1'b0, s, HPR_HW_FIRST, w[15:0], s0);
      hw(1'b0, s, ~HPR_HW_FIRST, w[31:16], s1);
   endtask : wr32

   task automatic rd32(input logic [1:0] s, input logic [31:0] w,
      output int s0, output int s1);
      exp_q.push_back({4'h4, 17'h0, w[15:0]});
      exp_q.push_back({4'h4, 17'h0, w[31:16]});
      hw(1'b1, s, HPR_HW_FIRST, 16'h0000, s0);
      hw(1'b1, s, ~HPR_HW_FIRST, 16'h0000, s1);
   endtask : rd32

   // Clears one stall cause well after the access has begun to wait.
   task automatic later(input int which);
      // The buffer stall only starts after the second half ends.
      repeat (which == 4 ? 32 : 20) @(negedge clk_sys_in);
      case (which)
         0: abusy = 1'b0;
         1: rbusy = 1'b0;
         2: flush = 1'b0;
         3: wemp = 1'b1;
         4: wrdy = 1'b1;
         default: ravl = 1'b1;
      endcase
   endtask : later

   ////////////////////////////////////////////////////////////////////////
   always @(posedge clk_sys_in) begin
      if (!reset_in) begin
         if (cw)
            take(4'h1, {1'b0, rword});
         if (aw)
            take(4'h2, {1'b0, rword});
         if (wv && wrdy)
            take(4'h3, {wai, wword});
         if (done)
            take(4'h4, {17'h0, word});
         if (rtk)
            takes++;
      end
   end

   // Memory side: answers each fetch after ten cycles.
   always @(negedge clk_sys_in) begin
      fdone <= 1'b0;
      if (freq)
         fcnt <= 10;
      else if (fcnt == 1) begin
         fcnt <= 0;
         fdone <= 1'b1;
      end else if (fcnt != 0)
         fcnt <= fcnt - 1;
   end

   initial begin
      repeat (20000) @(posedge clk_sys_in);
      bad_count++;
      $display("mismatch watchdog expected done seen hang");
      give_verdict();
   end

   initial begin
      int s0, s1;
      logic [31:0] w;
      logic bad;
      w = $urandom(32'h437e76e6);
      repeat (8) @(negedge clk_sys_in);
      reset_in = 1'b0;
      @(negedge clk_sys_in);
      `CHK("ready after reset", 1'b1, ready)
      `CHK("enable after reset", 1'b0, oe)
      for (int i = 0; i < 4; i++) begin
         host_u.idle_check(3'(12'b101_110_000_011 >> (9 - 3 * i)), bad);
         `CHK("no access strobe", 1'b0, bad)
      end
      w = $urandom();
      exp_q.push_back({4'h1, 1'b0, w});
      wr32(HPR_SEL_CTRL, w, s0, s1);
      `CHK("ctrl write stall", 0, s0 + s1)
      cval = $urandom();
      rd32(HPR_SEL_CTRL, cval, s0, s1);
      `CHK("ctrl read stall", 0, s0 + s1)
      w = $urandom();
      exp_q.push_back({4'h2, 1'b0, w});
      wr32(HPR_SEL_ADDR, w, s0, s1);
      `CHK("addr first half stall", 0, s0)
      `CHK("addr post stall", 1'b1, s1 >= 2)
      for (int k = 0; k < 3; k++) begin
         w = $urandom();
         exp_q.push_back({4'h2, 1'b0, w});
         if (k == 0) abusy = 1'b1;
         if (k == 1) rbusy = 1'b1;
         if (k == 2) wemp = 1'b0;
         fork
            wr32(HPR_SEL_ADDR, w, s0, s1);
            later(k == 2 ? 3 : k);
         join
         `CHK("addr stalled write", 1'b1, s0 >= 10)
      end
      rd32(HPR_SEL_ADDR, w, s0, s1);
      `CHK("addr read stall", 0, s0 + s1)
      // Receiver stalls: second word fills the buffer until it drains.
      wrdy = 1'b0;
      w = $urandom();
      exp_q.push_back({4'h3, 1'b1, w});
      wr32(HPR_SEL_DINC, w, s0, s1);
      `CHK("data write stall", 0, s0 + s1)
      w = $urandom();
      exp_q.push_back({4'h3, 1'b1, w});
      fork
         wr32(HPR_SEL_DINC, w, s0, s1);
         later(4);
      join
      `CHK("full buffer stall", 1'b1, s1 >= 10)
      `CHK("buffer drained", 1'b0, wv)
      flush = 1'b1;
      w = $urandom();
      exp_q.push_back({4'h3, 1'b1, w});
      fork
         wr32(HPR_SEL_DINC, w, s0, s1);
         later(2);
      join
      `CHK("flush stall", 1'b1, s0 >= 10)
      w = $urandom();
      exp_q.push_back({4'h3, 1'b0, w});
      wr32(HPR_SEL_DFIX, w, s0, s1);
      `CHK("fixed first half stall", 0, s0)
      `CHK("fixed commit stall", 1'b1, s1 >= 2)
      fdat = $urandom();
      rd32(HPR_SEL_DFIX, fdat, s0, s1);
      `CHK("fetch stall", 1'b1, s0 >= 5)
      `CHK("fixed second half stall", 0, s1)
      ravl = 1'b1;
      rdat = $urandom();
      rd32(HPR_SEL_DINC, rdat, s0, s1);
      `CHK("read hit stall", 0, s0 + s1)
      ravl = 1'b0;
      rdat = $urandom();
      fork
         rd32(HPR_SEL_DINC, rdat, s0, s1);
         later(5);
      join
      `CHK("read miss stall", 1'b1, s0 >= 10)
      `CHK("read miss second half", 0, s1)
      repeat (10) @(negedge clk_sys_in);
      `CHK("read fifo pops", 2, takes)
      `CHK("results left", 0, exp_q.size())
      give_verdict();
   end
endmodule : hpr_ready_logic_tb
